// *** core/sffc_regs.vh ***
// Offsets, field positions, reset values and counts of the serial format block.
`ifndef SFFC_REGS_VH
`define SFFC_REGS_VH

`define SFFC_ADDR_W          4
`define SFFC_OFS_FORMAT      4'h0
`define SFFC_OFS_STATE       4'h4

`define SFFC_FORMAT_RESET    8'h00

`define SFFC_BIT_SYNC_MODE   7
`define SFFC_BIT_CHAR_LEN    6
`define SFFC_BIT_PARITY_EN   5
`define SFFC_BIT_PARITY_ODD  4
`define SFFC_BIT_STOP_TWO    3
`define SFFC_BIT_MULTIPROC   2
`define SFFC_BIT_CKS_HI      1
`define SFFC_BIT_CKS_LO      0

`define SFFC_CKS_DIV1        2'h0
`define SFFC_CKS_DIV4        2'h1
`define SFFC_CKS_DIV16       2'h2
`define SFFC_CKS_DIV64       2'h3

`define SFFC_PRE_LAST_DIV4   6'h03
`define SFFC_PRE_LAST_DIV16  6'h0f
`define SFFC_PRE_LAST_DIV64  6'h3f

`endif

// *** core/sffc_core.v ***
// Serial frame format register with its decoded format outputs and prescaler.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sffc_regs.vh"

// Behaviour
// - Format register readable, writable, cleared on reset/standby
// - Top bit selects asynchronous or synchronous mode
// - Async: 8 or 7 bits; sync: always 8
// - Seven-bit characters never send the data MSB
// - Parity added and checked only in async
// - Polarity bit selects even or odd parity
// - Async sends one or two stop bits
// - Receiver checks only the first stop bit
// - Multiprocessor format overrides parity settings in async
// - Clock select: undivided, /4, /16, /64 prescale
module sffc_core (
	// Clock, reset and enable.
	input  wire        mclk_i,
	input  wire        rstn_i,
	input  wire        clk_en_i,
	input  wire        standby_i,
	// Avalon-MM slave.
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	// Character data seen by the shift logic.
	input  wire [7:0]  tx_data_i,
	input  wire [7:0]  rx_char_i,
	input  wire        rx_parity_i,
	// Steering outputs.
	output reg         sync_mode_o,
	output reg         char_7bit_o,
	output reg         parity_active_o,
	output reg         parity_odd_o,
	output reg  [1:0]  tx_stop_count_o,
	output reg  [1:0]  rx_stop_check_o,
	output reg         multiproc_active_o,
	output reg  [7:0]  tx_char_o,
	output reg         tx_parity_bit_o,
	output reg         rx_parity_err_o,
	output reg         prescale_tick_o
);

	reg  [7:0] serial_format_mode_reg;
	reg  [7:0] serial_format_mode_next;
	reg  [5:0] pre_cnt_reg;
	reg  [5:0] pre_last;
	reg  [31:0] rd_next;
	wire       req;
	wire       wr_fmt;

	wire       fm_sync   = serial_format_mode_reg[`SFFC_BIT_SYNC_MODE];
	wire       fm_chr7   = serial_format_mode_reg[`SFFC_BIT_CHAR_LEN];
	wire       fm_pe     = serial_format_mode_reg[`SFFC_BIT_PARITY_EN];
	wire       fm_odd    = serial_format_mode_reg[`SFFC_BIT_PARITY_ODD];
	wire       fm_stop2  = serial_format_mode_reg[`SFFC_BIT_STOP_TWO];
	wire       fm_mp     = serial_format_mode_reg[`SFFC_BIT_MULTIPROC];
	wire [1:0] fm_cks    = {serial_format_mode_reg[`SFFC_BIT_CKS_HI],
	                        serial_format_mode_reg[`SFFC_BIT_CKS_LO]};

	// Decoded format, each term valid for the current mode only.
	wire       async_chr7  = ~fm_sync & fm_chr7;
	wire       par_on      = ~fm_sync & ~fm_mp & fm_pe;
	wire       par_odd     = par_on & fm_odd;
	wire       mp_on       = ~fm_sync & fm_mp;
	wire [1:0] stops_tx    = fm_sync ? 2'h0 : (fm_stop2 ? 2'h2 : 2'h1);
	wire [7:0] tx_masked   = async_chr7 ? {1'b0, tx_data_i[6:0]} : tx_data_i;

	// Parity over the active data bits; odd sense inverts the even bit.
	function parity_of;
		input [7:0] data;
		input       seven;
		input       odd;
		begin
			parity_of = (seven ? ^data[6:0] : ^data) ^ odd;
		end
	endfunction

	assign req    = avs_read_i | avs_write_i;
	assign wr_fmt = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0] &
	                (avs_address_i == `SFFC_OFS_FORMAT);

	always @* begin
		serial_format_mode_next = serial_format_mode_reg;
		if (standby_i) begin
			serial_format_mode_next = `SFFC_FORMAT_RESET;
		end else if (wr_fmt) begin
			serial_format_mode_next = avs_writedata_i[7:0];
		end
	end

	always @* begin
		case (avs_address_i)
			`SFFC_OFS_FORMAT: rd_next = {24'h000000, serial_format_mode_reg};
			`SFFC_OFS_STATE:  rd_next = {22'h0, pre_cnt_reg, async_chr7,
			                              par_on, par_odd, mp_on};
			default:          rd_next = 32'h00000000;
		endcase
	end

	// Terminal count of the prescaler for the selected division.
	always @* begin
		case (fm_cks)
			`SFFC_CKS_DIV1:  pre_last = 6'h00;
			`SFFC_CKS_DIV4:  pre_last = `SFFC_PRE_LAST_DIV4;
			`SFFC_CKS_DIV16: pre_last = `SFFC_PRE_LAST_DIV16;
			`SFFC_CKS_DIV64: pre_last = `SFFC_PRE_LAST_DIV64;
			default:         pre_last = 6'h00;
		endcase
	end

	always @(posedge mclk_i) begin
		if (!rstn_i) begin
			serial_format_mode_reg <= `SFFC_FORMAT_RESET;
			avs_waitrequest_o      <= 1'b1;
			avs_readdata_o         <= 32'h00000000;
			pre_cnt_reg            <= 6'h00;
			prescale_tick_o        <= 1'b0;
			sync_mode_o            <= 1'b0;
			char_7bit_o            <= 1'b0;
			parity_active_o        <= 1'b0;
			parity_odd_o           <= 1'b0;
			tx_stop_count_o        <= 2'h1;
			rx_stop_check_o        <= 2'h1;
			multiproc_active_o     <= 1'b0;
			tx_char_o              <= 8'h00;
			tx_parity_bit_o        <= 1'b0;
			rx_parity_err_o        <= 1'b0;
		end else if (clk_en_i) begin
			serial_format_mode_reg <= serial_format_mode_next;
			// One wait cycle per request; the access completes on the edge after it.
			if (req && avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b0;
				avs_readdata_o    <= rd_next;
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
			// Any format write restarts the count so the first period after it has the full new length.
			if (standby_i || pre_cnt_reg >= pre_last || wr_fmt) begin
				pre_cnt_reg <= 6'h00;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 6'h01;
			end
			prescale_tick_o    <= ~standby_i & (pre_cnt_reg >= pre_last);
			sync_mode_o        <= fm_sync;
			char_7bit_o        <= async_chr7;
			parity_active_o    <= par_on;
			parity_odd_o       <= par_odd;
			tx_stop_count_o    <= stops_tx;
			rx_stop_check_o    <= fm_sync ? 2'h0 : 2'h1;
			multiproc_active_o <= mp_on;
			tx_char_o          <= tx_masked;
			tx_parity_bit_o    <= par_on & parity_of(tx_data_i, async_chr7, fm_odd);
			rx_parity_err_o    <= par_on &
			                      (parity_of(rx_char_i, async_chr7, fm_odd) != rx_parity_i);
		end
	end

endmodule // sffc_core
`default_nettype wire

// *** sim/sffc_core_assertions.sv ***
// Checker for the bus handshake and steering outputs of the format block.
`timescale 1ns/1ps
`default_nettype none
module sffc_core_chk (
	// Watched ports.
	input wire logic       mclk_i,
	input wire logic       rstn_i,
	input wire logic       clk_en_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic       sync_mode_o,
	input wire logic       char_7bit_o,
	input wire logic       parity_active_o,
	input wire logic       parity_odd_o,
	input wire logic [1:0] tx_stop_count_o,
	input wire logic [1:0] rx_stop_check_o,
	input wire logic       multiproc_active_o,
	input wire logic [7:0] tx_char_o,
	input wire logic       tx_parity_bit_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i || !clk_en_i);
	sequence s_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ack)
		else $error("bus answer not after one wait");
	a_wait_pulse: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
		else $error("wait low too long");
	a_sync_plain: assert property (sync_mode_o |-> tx_stop_count_o == 2'h0 && !char_7bit_o && !parity_active_o && !multiproc_active_o)
		else $error("sync mode frame extras");
	a_async_stop: assert property (!sync_mode_o |-> tx_stop_count_o inside {2'h1, 2'h2} && rx_stop_check_o == 2'h1)
		else $error("stop counts wrong");
	a_mp_parity: assert property (multiproc_active_o |-> !parity_active_o && !parity_odd_o)
		else $error("parity with multiproc");
	a_odd_gated: assert property (parity_odd_o |-> parity_active_o)
		else $error("odd without parity");
	a_seven_msb: assert property (char_7bit_o |-> !tx_char_o[7])
		else $error("msb sent in seven bit");
	a_parity_sum: assert property (tx_parity_bit_o == (parity_active_o && (^tx_char_o ^ parity_odd_o)))
		else $error("parity bit wrong");
endmodule // sffc_core_chk
bind sffc_core sffc_core_chk chk_u (.*);
`default_nettype wire

// *** sim/test_sffc_core.sv ***
// Self-checking bench for the serial format register block.
`timescale 1ns/1ps
`default_nettype none
module test_sffc_core;
	logic        mclk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        standby_i = 1'b0;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	wire  [31:0] avs_readdata_o;
	wire         avs_waitrequest_o, sync_mode_o, char_7bit_o, parity_active_o, parity_odd_o;
	wire         multiproc_active_o, tx_parity_bit_o, rx_parity_err_o, prescale_tick_o;
	wire  [1:0]  tx_stop_count_o, rx_stop_check_o;
	wire  [7:0]  tx_char_o;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          ticks = 0;
	int          t0;
	logic [7:0]  rdat;
	logic [7:0]  vals [5] = '{8'h38, 8'h64, 8'hfc, 8'h50, 8'h20};
	logic [15:0] outs [5] = '{16'h3981, 16'h4601, 16'h8081, 16'h4401, 16'h2481};
	sffc_core dut_u (.*, .clk_en_i(1'b1), .avs_byteenable_i(4'hf), .tx_data_i(8'h81),
		.rx_char_i(8'h00), .rx_parity_i(1'b0));
	always #2 mclk_i = ~mclk_i;
	task cmp(input [15:0] g, input [15:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task bus(input [3:0] a, input w, input [7:0] d);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {24'h0, d};
		@(posedge mclk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
		rdat = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		ticks <= ticks + prescale_tick_o;
		if (cyc == 3000) begin
			fails++;
			print_verdict;
		end
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		bus(4'h0, 1'b0, 8'h00);
		cmp(rdat, 16'h0);
		foreach (vals[i]) begin
			bus(4'h0, 1'b1, vals[i]);
			bus(4'h0, 1'b0, 8'h00);
			cmp(rdat, vals[i]);
			cmp({sync_mode_o, char_7bit_o, parity_active_o, parity_odd_o, tx_stop_count_o,
				multiproc_active_o, tx_parity_bit_o, tx_char_o}, outs[i]);
			cmp({15'h0, rx_parity_err_o}, {15'h0, outs[i][12]});
		end
		for (int k = 0; k < 4; k++) begin
			bus(4'h0, 1'b1, k[7:0]);
			@(posedge mclk_i);
			t0 = ticks;
			repeat (64) @(posedge mclk_i);
			cmp(16'(ticks - t0), 16'd64 >> (2 * k));
		end
		bus(4'h0, 1'b1, 8'h64);
		bus(4'h4, 1'b0, 8'h00);
		cmp({12'h0, rdat[3:0]}, 16'h9);
		bus(4'h8, 1'b0, 8'h00);
		cmp(rdat, 16'h0);
		bus(4'h0, 1'b1, 8'hff);
		standby_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		standby_i <= 1'b0;
		bus(4'h0, 1'b0, 8'h00);
		cmp(rdat, 16'h0);
		print_verdict;
	end
endmodule // test_sffc_core
`default_nettype wire
